// ---- pkg/ida_map.svh ----
// constants for the indirect data addressing unit: widths, the map of
// pointer port and byte addresses, and reset values
// assumes a 12-bit data address space and an 8-bit data path
`ifndef IDA_MAP_SVH
`define IDA_MAP_SVH

`define IDA_ADDR_W 12
`define IDA_BYTE_W 8
`define IDA_NUM_PTR 3
// pointer n owns eight addresses starting at base + 8*n
`define IDA_BLK_BASE 12'hfd8
`define IDA_BLK_SHIFT 3
// offsets inside one pointer block
`define IDA_OFF_PLAIN 3'h0
`define IDA_OFF_POST_DECREMENT_PORT 3'h1
`define IDA_OFF_POST_INCREMENT_PORT 3'h2
`define IDA_OFF_PRE_INCREMENT_PORT 3'h3
`define IDA_OFF_INDEXED 3'h4
`define IDA_OFF_LOW 3'h5
`define IDA_OFF_HIGH 3'h6
// bit position where the high byte starts inside the pointer
`define IDA_HI_LSB 8
`define IDA_PTR_RST 12'h000

`endif

// ---- pkg/ida_pkg.sv ----
// types shared by the indirect data addressing unit
// assumes ida_map.svh is on the include path
`include "ida_map.svh"

package ida_pkg;

  typedef logic [`IDA_ADDR_W-1:0] ptr_t;
  typedef logic [`IDA_BYTE_W-1:0] byte_t;

  // order follows the block offsets 0..4
  typedef enum logic [2:0] {
    PK_PLAIN,
    PK_POST_DECREMENT_PORT,
    PK_POST_INCREMENT_PORT,
    PK_PRE_INCREMENT_PORT,
    PK_INDEXED
  } port_kind_t;

  typedef enum logic [1:0] {
    STEP_NONE,
    STEP_INC,
    STEP_DEC
  } step_t;

  typedef struct packed {
    logic is_port;
    logic is_byte;
    logic byte_hi;
    logic [1:0] idx;
    port_kind_t kind;
  } addr_class_t;

endpackage

// ---- pkg/ptr_ctl_if.sv ----
// control and value of one data pointer between the top and its unit
// assumes ida_pkg is compiled first
`timescale 1ns/10ps

interface ptr_ctl_if;
  import ida_pkg::*;

  step_t step;
  logic load_lo;
  logic load_hi;
  byte_t load_data;
  ptr_t value;

  modport ctl (output step, output load_lo, output load_hi,
               output load_data, input value);
  modport unit (input step, input load_lo, input load_hi,
                input load_data, output value);
endinterface

// ---- hdl/ptr_unit.sv ----
// one 12-bit data pointer with byte loads and automatic step
// assumes at most one of load_lo, load_hi, step is active per cycle
`timescale 1ns/10ps

module ptr_unit
  import ida_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  ptr_ctl_if.unit ctl
);

  ptr_t val_reg;
  ptr_t val_next;

  // next pointer value: a byte load wins over any step
  always_comb begin
    val_next = val_reg;
    if (ctl.load_lo) begin
      val_next[`IDA_HI_LSB-1:0] = ctl.load_data;
    end else if (ctl.load_hi) begin
      // only the low nibble of the high byte exists
      val_next[`IDA_ADDR_W-1:`IDA_HI_LSB] =
        ctl.load_data[`IDA_ADDR_W-`IDA_HI_LSB-1:0];
    end else begin
      // RULE11 full-width step
      // RULE14 wraps modulo 4096
      unique case (ctl.step)
        STEP_INC: val_next = val_reg + ptr_t'(1);
        STEP_DEC: val_next = val_reg - ptr_t'(1);
        STEP_NONE: val_next = val_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      val_reg <= `IDA_PTR_RST;
    end else begin
      val_reg <= val_next;
    end
  end

  assign ctl.value = val_reg;

  chk_carry_into_high: assert property ( // RULE11
    @(posedge mclk) disable iff (!rst_b)
    (ctl.step == STEP_INC && !ctl.load_lo && !ctl.load_hi &&
     val_reg[7:0] == 8'hff && val_reg[11:8] != 4'hf)
    |=> val_reg[11:8] == $past(val_reg[11:8]) + 4'h1)
    else $error("increment carry did not reach the high byte");

  chk_wrap_to_zero: assert property ( // RULE14
    @(posedge mclk) disable iff (!rst_b)
    (ctl.step == STEP_INC && !ctl.load_lo && !ctl.load_hi &&
     val_reg == 12'hfff) |=> val_reg == 12'h000)
    else $error("pointer increment did not wrap to zero");

endmodule

// ---- hdl/addr_decode.sv ----
// classifies a data address as a pointer port, a pointer byte, or memory
// assumes the pointer blocks are contiguous and 8-address aligned
`timescale 1ns/10ps

module addr_decode
  import ida_pkg::*;
#(
  parameter int NUM_PTR = `IDA_NUM_PTR
)
(
  input wire ptr_t addr,
  output addr_class_t cls
);

  ptr_t off;
  logic in_blk;
  logic [2:0] sub;

  // offset into the pointer blocks and its position inside one block
  always_comb begin
    off = addr - `IDA_BLK_BASE;
    in_blk = (addr >= `IDA_BLK_BASE) &&
             (off < ptr_t'(NUM_PTR << `IDA_BLK_SHIFT));
    sub = off[2:0];
    cls = '0;
    if (in_blk) begin
      cls.idx = off[4:3];
      cls.is_port = (sub <= `IDA_OFF_INDEXED);
      cls.is_byte = (sub == `IDA_OFF_LOW) || (sub == `IDA_OFF_HIGH);
      cls.byte_hi = (sub == `IDA_OFF_HIGH);
      // port kinds are declared in block-offset order
      cls.kind = (sub <= `IDA_OFF_INDEXED) ? port_kind_t'(sub) : PK_PLAIN;
    end
  end

endmodule

// ---- hdl/indirect_addr.sv ----
// indirect data addressing unit: three pointers, port decode, address
// generation and a two-stage access pipeline toward data memory
// assumes the core offers at most one access per cycle and that data
// memory returns mem_rdata in the same cycle as mem_en
//
// Summary of operation
// RULE1: three independent 12-bit pointers, each read and written as two bytes
// RULE2: each pointer reaches the full 4096-byte data space
// RULE3: plain port operand accesses memory at the pointer's address instead
// RULE4: indirect read landing on any port returns zero and sets zero flag
// RULE5: indirect write landing on any port is a no-op, flags unchanged
// RULE6: five ports per pointer select none, post_decrement_port, post_increment_port, pre_increment_port, indexed
// RULE7: post-increment uses current pointer, then adds one
// RULE8: post-decrement uses current pointer, then subtracts one
// RULE9: pre-increment adds one first, then uses the new value
// RULE10: indexed uses pointer plus signed working register, changes nothing
// RULE11: step covers all 12 bits, low byte carry reaches high byte
// RULE12: pointer steps never touch any status flag
// RULE13: indirect write to a pointer byte stores data, suppresses step
// RULE14: steps and indexed sum wrap modulo 4096
`timescale 1ns/10ps

module indirect_addr
  import ida_pkg::*;
#(
  parameter int NUM_PTR = `IDA_NUM_PTR
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire ptr_t req_addr,
  input wire logic req_write,
  input wire byte_t req_wdata,
  input wire byte_t working_reg,
  input wire byte_t mem_rdata,
  output logic mem_en,
  output logic mem_we,
  output ptr_t mem_addr,
  output byte_t mem_wdata,
  output logic rsp_valid,
  output byte_t rsp_data,
  output logic rsp_zero,
  output logic rsp_nop
);

  ptr_ctl_if pc[NUM_PTR] ();

  ptr_t ptr_q [NUM_PTR];
  step_t ptr_step [NUM_PTR];
  logic ptr_ld_lo [NUM_PTR];
  logic ptr_ld_hi [NUM_PTR];

  addr_class_t op_cls;
  addr_class_t ea_cls;
  ptr_t sel_ptr;
  ptr_t w_ext;
  ptr_t ea;
  step_t op_step;
  logic self_ref;
  logic byte_hit;
  logic mem_hit;
  byte_t byte_val;

  logic mem_en_reg, mem_en_next;
  logic mem_we_reg, mem_we_next;
  ptr_t mem_addr_reg, mem_addr_next;
  byte_t mem_wdata_reg, mem_wdata_next;
  logic s1_valid_reg, s1_valid_next;
  byte_t s1_ldata_reg, s1_ldata_next;
  logic s1_zero_reg, s1_zero_next;
  logic s1_nop_reg, s1_nop_next;
  logic rsp_valid_reg, rsp_valid_next;
  byte_t rsp_data_reg, rsp_data_next;
  logic rsp_zero_reg, rsp_zero_next;
  logic rsp_nop_reg, rsp_nop_next;

  // RULE1 one pointer unit each
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    assign pc[i].step = ptr_step[i];
    assign pc[i].load_lo = ptr_ld_lo[i];
    assign pc[i].load_hi = ptr_ld_hi[i];
    assign pc[i].load_data = req_wdata;
    assign ptr_q[i] = pc[i].value;
    ptr_unit u_ptr (
      .mclk(mclk),
      .rst_b(rst_b),
      .ctl(pc[i].unit)
    );
  end

  // classify the operand as given by the instruction
  addr_decode #(.NUM_PTR(NUM_PTR)) u_dec_op (
    .addr(req_addr),
    .cls(op_cls)
  );

  // classify the address that the access finally lands on
  addr_decode #(.NUM_PTR(NUM_PTR)) u_dec_ea (
    .addr(ea),
    .cls(ea_cls)
  );

  // the pointer is read before its own step lands, so post-steps need no
  // bypass; a back-to-back request sees the stepped value one edge later
  // effective address: a port operand is replaced by its pointer
  always_comb begin
    sel_ptr = ptr_q[op_cls.idx];
    w_ext = {{(`IDA_ADDR_W-`IDA_BYTE_W){working_reg[`IDA_BYTE_W-1]}},
             working_reg};
    ea = req_addr;
    op_step = STEP_NONE;
    // RULE3 port is not a register
    if (op_cls.is_port) begin
      // RULE6 port picks the update
      unique case (op_cls.kind)
        PK_PLAIN: ea = sel_ptr;
        // RULE8 address then decrement
        PK_POST_DECREMENT_PORT: begin
          ea = sel_ptr;
          op_step = STEP_DEC;
        end
        // RULE7 address then increment
        PK_POST_INCREMENT_PORT: begin
          ea = sel_ptr;
          op_step = STEP_INC;
        end
        // RULE9 increment then address
        PK_PRE_INCREMENT_PORT: begin
          ea = sel_ptr + ptr_t'(1);
          op_step = STEP_INC;
        end
        // RULE10 signed offset, no step
        // RULE14 sum wraps at 12 bits
        PK_INDEXED: ea = sel_ptr + w_ext;
      endcase
    end
  end

  // request handling and the two pipeline stages
  always_comb begin
    self_ref = req_valid && op_cls.is_port && ea_cls.is_port;
    byte_hit = req_valid && ea_cls.is_byte;
    mem_hit = req_valid && !ea_cls.is_port && !ea_cls.is_byte;
    // upper nibble of the high byte reads as zero
    byte_val = ea_cls.byte_hi ?
      byte_t'(ptr_q[ea_cls.idx][`IDA_ADDR_W-1:`IDA_HI_LSB]) :
      ptr_q[ea_cls.idx][`IDA_HI_LSB-1:0];
    for (int k = 0; k < NUM_PTR; k++) begin
      // RULE13 byte write kills the step
      // RULE12 steps drive no flag
      ptr_step[k] = (req_valid && op_cls.is_port && op_cls.idx == 2'(k) &&
                     !(req_write && ea_cls.is_byte)) ? op_step : STEP_NONE;
      // RULE13 data goes to the byte
      ptr_ld_lo[k] = byte_hit && req_write && !ea_cls.byte_hi &&
                     ea_cls.idx == 2'(k);
      ptr_ld_hi[k] = byte_hit && req_write && ea_cls.byte_hi &&
                     ea_cls.idx == 2'(k);
    end
    // RULE2 full 12-bit memory address
    mem_en_next = mem_hit;
    mem_we_next = mem_hit && req_write;
    mem_addr_next = ea;
    mem_wdata_next = req_wdata;
    s1_valid_next = req_valid;
    s1_ldata_next = (byte_hit && !req_write) ? byte_val : '0;
    // RULE4 self read gives zero
    s1_zero_next = self_ref && !req_write;
    // RULE5 self write does nothing
    s1_nop_next = self_ref && req_write;
    rsp_valid_next = s1_valid_reg;
    rsp_data_next = (mem_en_reg && !mem_we_reg) ? mem_rdata : s1_ldata_reg;
    rsp_zero_next = s1_zero_reg;
    rsp_nop_next = s1_nop_reg;
  end

  // registers only; the answer follows the request by two edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_en_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
      s1_valid_reg <= 1'b0;
      s1_ldata_reg <= '0;
      s1_zero_reg <= 1'b0;
      s1_nop_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      rsp_zero_reg <= 1'b0;
      rsp_nop_reg <= 1'b0;
    end else begin
      mem_en_reg <= mem_en_next;
      mem_we_reg <= mem_we_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      s1_valid_reg <= s1_valid_next;
      s1_ldata_reg <= s1_ldata_next;
      s1_zero_reg <= s1_zero_next;
      s1_nop_reg <= s1_nop_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_zero_reg <= rsp_zero_next;
      rsp_nop_reg <= rsp_nop_next;
    end
  end

  assign mem_en = mem_en_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_zero = rsp_zero_reg;
  assign rsp_nop = rsp_nop_reg;

  // checks: pointer updates and address generation against the operand
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_plain_port_addr: assert property ( // RULE3
    (mem_hit && op_cls.is_port && op_cls.kind == PK_PLAIN)
    |=> mem_en && mem_addr == $past(sel_ptr) &&
        ptr_q[$past(op_cls.idx)] == $past(sel_ptr))
    else $error("plain port did not use the pointer unchanged");

  chk_post_increment_port_step: assert property ( // RULE7
    (mem_hit && op_cls.is_port && op_cls.kind == PK_POST_INCREMENT_PORT)
    |=> mem_addr == $past(sel_ptr) &&
        ptr_q[$past(op_cls.idx)] == $past(sel_ptr) + 12'h001)
    else $error("post-increment address or step wrong");

  chk_post_decrement_port_step: assert property ( // RULE8
    (mem_hit && op_cls.is_port && op_cls.kind == PK_POST_DECREMENT_PORT)
    |=> mem_addr == $past(sel_ptr) &&
        ptr_q[$past(op_cls.idx)] == $past(sel_ptr) - 12'h001)
    else $error("post-decrement address or step wrong");

  chk_pre_increment_port_addr: assert property ( // RULE9
    (mem_hit && op_cls.is_port && op_cls.kind == PK_PRE_INCREMENT_PORT)
    |=> mem_addr == $past(sel_ptr) + 12'h001 &&
        ptr_q[$past(op_cls.idx)] == mem_addr)
    else $error("pre-increment did not address the new value");

  chk_indexed_sum: assert property ( // RULE10
    (mem_hit && op_cls.is_port && op_cls.kind == PK_INDEXED)
    |=> mem_addr == $past(sel_ptr) +
        {{4{$past(working_reg[7])}}, $past(working_reg)} &&
        ptr_q[$past(op_cls.idx)] == $past(sel_ptr))
    else $error("indexed address wrong or pointer moved");

  chk_self_read_zero: assert property ( // RULE4
    (self_ref && !req_write)
    |=> !mem_en ##1 rsp_valid && rsp_zero && rsp_data == 8'h00)
    else $error("read through a port of a port did not give zero");

  chk_self_write_nop: assert property ( // RULE5
    (self_ref && req_write)
    |=> !mem_en ##1 rsp_valid && rsp_nop && !rsp_zero)
    else $error("write through a port of a port was not a no-op");

  chk_byte_write_load: assert property ( // RULE13
    (byte_hit && req_write && !ea_cls.byte_hi && op_cls.is_port &&
     op_cls.idx != ea_cls.idx)
    |=> ptr_q[$past(ea_cls.idx)][7:0] == $past(req_wdata) &&
        ptr_q[$past(op_cls.idx)] == $past(sel_ptr))
    else $error("pointer byte write lost or step not suppressed");

  chk_zero_flag_cause: assert property ( // RULE12
    rsp_zero |-> $past(self_ref && !req_write, 2))
    else $error("zero flag raised by something other than a self read");

  // RULE13 own byte wins
  chk_same_ptr_load: assert property ( // RULE13
    (byte_hit && req_write && !ea_cls.byte_hi && op_cls.is_port &&
     op_cls.idx == ea_cls.idx)
    |=> ptr_q[$past(op_cls.idx)] ==
        {$past(sel_ptr[11:8]), $past(req_wdata)})
    else $error("byte write through own port stepped the pointer");

  // RULE2 direct full address
  chk_direct_addr: assert property ( // RULE2
    (mem_hit && !op_cls.is_port)
    |=> mem_en && mem_addr == $past(req_addr))
    else $error("direct access did not reach its own address");

  // RULE1 high nibble reads zero
  chk_high_nibble: assert property ( // RULE1
    (byte_hit && !req_write && ea_cls.byte_hi)
    |-> ##2 rsp_valid && rsp_data[7:4] == 4'h0)
    else $error("upper nibble of a pointer high byte read as nonzero");

  // RULE6 no port, no move
  for (genvar j = 0; j < NUM_PTR; j++) begin : g_chk
    chk_ptr_quiet: assert property ( // RULE6
      (ptr_step[j] == STEP_NONE && !ptr_ld_lo[j] && !ptr_ld_hi[j])
      |=> ptr_q[j] == $past(ptr_q[j]))
      else $error("pointer moved with no step and no byte load");
  end

  cov_post_increment_port: cover property (
    mem_hit && op_cls.is_port && op_cls.kind == PK_POST_INCREMENT_PORT);
  cov_indexed_neg: cover property (
    mem_hit && op_cls.kind == PK_INDEXED && working_reg[7]);
  cov_self_read: cover property (self_ref && !req_write);
  cov_byte_write: cover property (byte_hit && req_write && op_cls.is_port);
  cov_same_ptr_load: cover property (
    byte_hit && req_write && op_cls.is_port && op_cls.idx == ea_cls.idx);

endmodule

// ---- dv/data_mem_model.sv ----
// data memory at the far side of the addressing unit
// assumes a combinational read in the strobe cycle and writes at mclk
`timescale 1ns/10ps

module data_mem_model
  import ida_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mem_en,
  input wire logic mem_we,
  input wire ptr_t mem_addr,
  input wire byte_t mem_wdata,
  output byte_t mem_rdata
);
  byte_t store [0:4095];
  byte_t idle_reg;

  // off the strobe the bus churns, so stale data cannot pass as real
  always_comb begin
    mem_rdata = mem_en ? store[mem_addr] : idle_reg;
  end

  // writes land at the strobe edge; idle pattern flips every cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idle_reg <= 8'ha5;
    end else begin
      idle_reg <= ~idle_reg;
      if (mem_en && mem_we) begin
        store[mem_addr] <= mem_wdata;
      end
    end
  end
endmodule

// ---- dv/test_indirect_addr.sv ----
// self-checking bench for the indirect data addressing unit
// assumes package, design and memory model are compiled first
`timescale 1ns/10ps
`include "ida_map.svh"

module test_indirect_addr
  import ida_pkg::*;
;

  logic mclk, rst_b, req_valid, req_write, mem_en, mem_we;
  logic rsp_valid, rsp_zero, rsp_nop;
  ptr_t req_addr, mem_addr;
  byte_t req_wdata, working_reg, mem_rdata, mem_wdata, rsp_data;
  int errors, checks_done, cycles;

  indirect_addr indirect_addr_inst (.mclk(mclk), .rst_b(rst_b),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
    .req_wdata(req_wdata), .working_reg(working_reg),
    .mem_rdata(mem_rdata), .mem_en(mem_en), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_zero(rsp_zero), .rsp_nop(rsp_nop));

  data_mem_model data_mem_model_inst (.mclk(mclk), .rst_b(rst_b),
    .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // the whole run needs about 140 cycles; a hang is cut at 2000
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      $display("Error run length expected below 2000 seen %0d", cycles);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  // address of offset off inside the block of pointer n
  function automatic ptr_t pa(input int n, input logic [2:0] off);
    return `IDA_BLK_BASE + ptr_t'(n << `IDA_BLK_SHIFT) + ptr_t'(off);
  endfunction

  // one request: strobe checked one edge later, answer two edges later
  task automatic acc(input ptr_t a, input logic w, input byte_t d,
                     input logic en, input ptr_t ea, input byte_t ed,
                     input logic ez, input logic enop);
    req_valid = 1'b1;
    req_addr = a;
    req_write = w;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
    chk("mem_en", 12'(en), 12'(mem_en));
    if (en) begin
      chk("mem_addr", ea, mem_addr);
      chk("mem_we", 12'(w), 12'(mem_we));
    end
    if (en && w) begin
      chk("mem_wdata", 12'(d), 12'(mem_wdata));
    end
    @(negedge mclk);
    chk("rsp_valid", 12'h001, 12'(rsp_valid));
    chk("rsp_data", 12'(ed), 12'(rsp_data));
    chk("rsp_zero", 12'(ez), 12'(rsp_zero));
    chk("rsp_nop", 12'(enop), 12'(rsp_nop));
  endtask

  task automatic wr(input ptr_t a, input byte_t d);
    acc(a, 1'b1, d, 1'b1, a, 8'h00, 1'b0, 1'b0);
  endtask

  // pointer bytes are loaded and read back directly, never via memory
  task automatic setp(input int n, input ptr_t v);
    acc(pa(n, 5), 1'b1, v[7:0], 1'b0, 12'h000, 8'h00, 1'b0, 1'b0);
    acc(pa(n, 6), 1'b1, {4'h0, v[11:8]}, 1'b0, 12'h000, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic getp(input int n, input ptr_t v);
    acc(pa(n, 5), 1'b0, 8'h00, 1'b0, 12'h000, v[7:0], 1'b0, 1'b0);
    acc(pa(n, 6), 1'b0, 8'h00, 1'b0, 12'h000, {4'h0, v[11:8]}, 1'b0, 1'b0);
  endtask

  task automatic t_post_increment_port();
    wr(12'h1ff, 8'h5a);
    wr(12'h200, 8'hc3);
    setp(0, 12'h1ff);
    acc(pa(0, 2), 1'b0, 8'h00, 1'b1, 12'h1ff, 8'h5a, 1'b0, 1'b0);
    acc(pa(0, 0), 1'b0, 8'h00, 1'b1, 12'h200, 8'hc3, 1'b0, 1'b0);
    getp(0, 12'h200);
    $display("test post_increment_port done");
  endtask

  task automatic t_post_decrement_port();
    acc(pa(0, 1), 1'b0, 8'h00, 1'b1, 12'h200, 8'hc3, 1'b0, 1'b0);
    acc(pa(0, 0), 1'b0, 8'h00, 1'b1, 12'h1ff, 8'h5a, 1'b0, 1'b0);
    getp(0, 12'h1ff);
    $display("test post_decrement_port done");
  endtask

  // wrap to zero leaves zero flag alone
  task automatic t_pre_increment_port();
    wr(12'h000, 8'h3c);
    setp(1, 12'hfff);
    acc(pa(1, 3), 1'b0, 8'h00, 1'b1, 12'h000, 8'h3c, 1'b0, 1'b0);
    getp(1, 12'h000);
    acc(pa(1, 1), 1'b0, 8'h00, 1'b1, 12'h000, 8'h3c, 1'b0, 1'b0);
    getp(1, 12'hfff);
    $display("test pre_increment_port done");
  endtask

  // both ends of the signed offset
  task automatic t_indexed();
    setp(2, 12'h005);
    working_reg = 8'h80;
    acc(pa(2, 4), 1'b1, 8'h77, 1'b1, 12'hf85, 8'h00, 1'b0, 1'b0);
    acc(12'hf85, 1'b0, 8'h00, 1'b1, 12'hf85, 8'h77, 1'b0, 1'b0);
    wr(12'h084, 8'h21);
    working_reg = 8'h7f;
    acc(pa(2, 4), 1'b0, 8'h00, 1'b1, 12'h084, 8'h21, 1'b0, 1'b0);
    getp(2, 12'h005);
    $display("test indexed done");
  endtask

  task automatic t_port_hit();
    setp(1, pa(0, 0));
    acc(pa(1, 0), 1'b0, 8'h00, 1'b0, 12'h000, 8'h00, 1'b1, 1'b0);
    acc(pa(1, 0), 1'b1, 8'h99, 1'b0, 12'h000, 8'h00, 1'b0, 1'b1);
    setp(1, pa(2, 4));
    acc(pa(1, 2), 1'b0, 8'h00, 1'b0, 12'h000, 8'h00, 1'b1, 1'b0);
    getp(1, pa(2, 4) + 12'h001);
    $display("test port hit done");
  endtask

  // write through a stepping port into a pointer byte
  task automatic t_byte_write();
    setp(0, pa(2, 5));
    acc(pa(0, 2), 1'b1, 8'h44, 1'b0, 12'h000, 8'h00, 1'b0, 1'b0);
    getp(0, pa(2, 5));
    getp(2, 12'h044);
    acc(pa(2, 6), 1'b1, 8'hf0, 1'b0, 12'h000, 8'h00, 1'b0, 1'b0);
    getp(2, 12'h044);
    setp(0, pa(0, 5));
    acc(pa(0, 2), 1'b1, 8'h66, 1'b0, 12'h000, 8'h00, 1'b0, 1'b0);
    getp(0, 12'hf66);
    $display("test byte write done");
  endtask

  // back to back, second request sees the first step
  task automatic t_back2back();
    setp(0, 12'h1ff);
    req_valid = 1'b1;
    req_addr = pa(0, 2);
    req_write = 1'b0;
    @(negedge mclk);
    chk("mem_addr", 12'h1ff, mem_addr);
    @(negedge mclk);
    req_valid = 1'b0;
    chk("mem_addr", 12'h200, mem_addr);
    chk("rsp_data", 12'h05a, 12'(rsp_data));
    @(negedge mclk);
    chk("rsp_valid", 12'h001, 12'(rsp_valid));
    chk("rsp_data", 12'h0c3, 12'(rsp_data));
    $display("test back to back done");
  endtask

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_addr = 12'h000;
    req_write = 1'b0;
    req_wdata = 8'h00;
    working_reg = 8'h00;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("mem_en", 12'h000, 12'(mem_en));
    chk("rsp_valid", 12'h000, 12'(rsp_valid));
    rst_b = 1'b1;
    @(negedge mclk);
    getp(0, 12'h000);
    t_post_increment_port();
    t_post_decrement_port();
    t_pre_increment_port();
    t_indexed();
    t_port_hit();
    t_byte_write();
    t_back2back();
    stop_test();
  end
endmodule
